//--- core/vstu_timer_unit.sv
// Purpose: servo timer unit: head, free-running, frame, duty, interval, tape, pwm
// Assumes: compare values are static inputs; no software register port
// Notes: pins are synchronised before use; pseudo-vsync and unmask outputs are pulses, head switches and record control are levels
`timescale 1ns/1ps

module vstu_timer_unit
    import vstu_pkg::*;
#(
    parameter int PWM_CYC = PWM_PERIOD_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // tach and control pins, asynchronous
    input wire logic drumPhaseTach,
    input wire logic drumFreqTach,
    input wire logic referenceSync,
    input wire logic capstanTach,
    input wire logic takeupReelTach,
    input wire logic supplyReelTach,
    input wire logic playback_control_pulse,
    input wire logic external_capture_pin,
    // configuration
    input wire vstu_compare_t compare,
    input wire vstu_pwm_duty_t pwmDuty,
    input wire logic dutyTickSlow,
    input wire logic [2:0] rtpTriggerSel,
    // results
    output vstu_capture_t capture,
    output vstu_irq_t irq,
    output logic realtimeOutputLoad,
    output logic vsyncUnmask,
    output logic videoHeadSwitch,
    output logic audioHeadSwitch,
    output logic pseudoVsyncPulse,
    output logic record_control_output,
    output logic [1:0] dutySample,
    output logic tachDividerOut,
    output logic [TAPE_W-1:0] tapeCount,
    output logic [NUM_PWM_HI+NUM_PWM_LO-1:0] pwmOut
);
    if (PWM_CYC < 2 || PWM_CYC >= (1 << PWM_CNT_W)) begin : gPwmCheck
        $error("PWM_CYC out of range");
    end

    logic [NUM_PINS-1:0] pinLevel, pinRise, pinFall;
    logic [NUM_TICKS-1:0] tick;
    logic [HEAD_W-1:0] head_timer;
    logic [EVT_W-1:0] drum_event_counter;
    logic internalHeadSwitch;
    logic [FRC_W-1:0] free_running_count;
    logic [TMR_W-1:0] frame_reference_timer, duty_timer;
    logic [TMR_W-1:0] interval_timer_a, interval_timer_b, remote_decode_timer;
    logic [EVT_W-1:0] tach_divider;
    logic [TAPE_W-1:0] tape_updown_counter;
    logic hitVideo, hitAudio, hitPseudo, hitVmask, hitIntB;

    vstu_edge_sync #(.N(NUM_PINS)) uSync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pinIn({external_capture_pin, playback_control_pulse, supplyReelTach,
                takeupReelTach, capstanTach, referenceSync, drumFreqTach, drumPhaseTach}),
        .level(pinLevel),
        .rise(pinRise),
        .fall(pinFall)
    );

    // tick prescalers; all run from reset so tick phases are deterministic
    localparam int TICK_DIV [NUM_TICKS] = '{DIV_1US, DIV_1P1US, DIV_125NS, DIV_2US};
    for (genvar i = 0; i < NUM_TICKS; i++) begin : gTick
        logic [TICK_CNT_W-1:0] cnt;
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                cnt <= '0;
                tick[i] <= 1'b0;
            end else if (cnt == TICK_CNT_W'(TICK_DIV[i] - 1)) begin
                cnt <= '0;
                tick[i] <= 1'b1;
            end else begin
                cnt <= cnt + 1'b1;
                tick[i] <= 1'b0;
            end
        end
    end

    // head timer restarts on each drum phase pulse and on each event match
    logic evtHit;
    assign evtHit = pinRise[PIN_DRUM_FREQ] &&
        (drum_event_counter == compare.drumEvent[0] ||
         drum_event_counter == compare.drumEvent[1] ||
         drum_event_counter == compare.drumEvent[2] ||
         drum_event_counter == compare.drumEvent[3]);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            drum_event_counter <= '0;
            internalHeadSwitch <= 1'b0;
        end else if (pinRise[PIN_DRUM_PHASE]) begin
            drum_event_counter <= '0;
            internalHeadSwitch <= 1'b0;
        end else if (pinRise[PIN_DRUM_FREQ]) begin
            drum_event_counter <= drum_event_counter + 1'b1;
            if (evtHit) begin
                internalHeadSwitch <= ~internalHeadSwitch;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            head_timer <= '0;
        end else if (pinRise[PIN_DRUM_PHASE] || evtHit) begin
            head_timer <= '0;
        end else if (tick[TK_1US]) begin
            head_timer <= head_timer + 1'b1;
        end
    end

    // coincidences fire once, on the tick that moves the timer past the compare value
    assign hitVideo = tick[TK_1US] && head_timer == compare.videoHeadDelay;
    assign hitAudio = tick[TK_1US] && head_timer == compare.audioHeadDelay;
    assign hitPseudo = tick[TK_1US] && head_timer == compare.pseudoVsync;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            videoHeadSwitch <= 1'b0;
            audioHeadSwitch <= 1'b0;
            pseudoVsyncPulse <= 1'b0;
        end else begin
            if (hitVideo) begin
                videoHeadSwitch <= internalHeadSwitch;
            end
            if (hitAudio) begin
                audioHeadSwitch <= internalHeadSwitch;
            end
            pseudoVsyncPulse <= hitPseudo;
        end
    end

    // free-running counter and its six captures
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            free_running_count <= '0;
        end else if (tick[TK_125NS]) begin
            free_running_count <= free_running_count + 1'b1;
        end
    end

    localparam int CAPT_PIN [NUM_FRC_CAPT] =
        '{PIN_REF, PIN_DRUM_PHASE, PIN_DRUM_FREQ, PIN_CAPSTAN, PIN_TAKEUP, PIN_SUPPLY};
    for (genvar c = 0; c < NUM_FRC_CAPT; c++) begin : gFrcCapt
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                capture.freeRun[c] <= '0;
            end else if (pinRise[CAPT_PIN[c]]) begin
                capture.freeRun[c] <= free_running_count;
            end
        end
    end

    // tach divider: its output pulse marks the capstan phase instant
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tach_divider <= '0;
            tachDividerOut <= 1'b0;
        end else begin
            tachDividerOut <= 1'b0;
            if (pinRise[PIN_CAPSTAN]) begin
                if (tach_divider == compare.tachDivider) begin
                    tach_divider <= '0;
                    tachDividerOut <= 1'b1;
                end else begin
                    tach_divider <= tach_divider + 1'b1;
                end
            end
        end
    end

    // frame reference timer, restarted by the frame reference sync
    logic hitFrame, hitRecord;
    assign hitFrame = tick[TK_1US] && frame_reference_timer == compare.frameReference;
    assign hitRecord = tick[TK_1US] && frame_reference_timer == compare.recordControl;
    assign hitVmask = tick[TK_1US] && frame_reference_timer == compare.vsyncMask;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frame_reference_timer <= '0;
        end else if (pinRise[PIN_REF]) begin
            frame_reference_timer <= '0;
        end else if (tick[TK_1US]) begin
            frame_reference_timer <= frame_reference_timer + 1'b1;
        end
    end

    // record control rises at the reference compare and falls at its own compare
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            record_control_output <= 1'b0;
            vsyncUnmask <= 1'b0;
            capture.capstanPhase <= '0;
        end else begin
            if (hitFrame) begin
                record_control_output <= 1'b1;
            end else if (hitRecord) begin
                record_control_output <= 1'b0;
            end
            vsyncUnmask <= hitVmask;
            if (tachDividerOut) begin
                capture.capstanPhase <= frame_reference_timer;
            end
        end
    end

    // duty timer: period captured and restarted on each control pulse rise
    logic dutyTick;
    assign dutyTick = dutyTickSlow ? tick[TK_1P1US] : tick[TK_1US];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            duty_timer <= '0;
            capture.pulsePeriod <= '0;
            dutySample <= '0;
        end else begin
            if (pinRise[PIN_PLAYBACK_CONTROL_PULSE]) begin
                capture.pulsePeriod <= duty_timer;
                duty_timer <= '0;
            end else if (dutyTick) begin
                duty_timer <= duty_timer + 1'b1;
            end
            for (int k = 0; k < 2; k++) begin
                if (dutyTick && duty_timer == compare.dutySample[k]) begin
                    dutySample[k] <= pinLevel[PIN_PLAYBACK_CONTROL_PULSE];
                end
            end
        end
    end

    // interval timers clear on their own match; the irq fires the same cycle
    logic hitIntA;
    assign hitIntA = interval_timer_a == compare.intervalA;
    assign hitIntB = interval_timer_b == compare.intervalB;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            interval_timer_a <= '0;
        end else if (tick[TK_1US]) begin
            interval_timer_a <= hitIntA ? '0 : interval_timer_a + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            interval_timer_b <= '0;
        end else if (tick[TK_2US]) begin
            interval_timer_b <= hitIntB ? '0 : interval_timer_b + 1'b1;
        end
    end

    // remote decode timer free-runs; both registers take the count on a pin rise
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            remote_decode_timer <= '0;
            capture.remoteDuty <= '0;
            capture.remotePeriod <= '0;
        end else begin
            if (tick[TK_2US]) begin
                remote_decode_timer <= remote_decode_timer + 1'b1;
            end
            if (pinRise[PIN_EXT]) begin
                capture.remoteDuty <= remote_decode_timer;
                capture.remotePeriod <= remote_decode_timer;
            end
        end
    end

    // tape counter; a rise and fall in one cycle cannot occur after edge detection
    logic tapeMatch, tapeUnder;
    assign tapeUnder = pinFall[PIN_PLAYBACK_CONTROL_PULSE] && tape_updown_counter == '0;
    assign tapeMatch = (pinRise[PIN_PLAYBACK_CONTROL_PULSE] &&
                        tape_updown_counter + 1'b1 == compare.tape) ||
                       (pinFall[PIN_PLAYBACK_CONTROL_PULSE] && tape_updown_counter - 1'b1 == compare.tape);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tape_updown_counter <= '0;
        end else if (pinRise[PIN_PLAYBACK_CONTROL_PULSE]) begin
            tape_updown_counter <= tape_updown_counter + 1'b1;
        end else if (pinFall[PIN_PLAYBACK_CONTROL_PULSE]) begin
            tape_updown_counter <= tape_updown_counter - 1'b1;
        end
    end
    assign tapeCount = tape_updown_counter;

    // interrupt pulses and port load trigger, registered
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq <= '0;
            realtimeOutputLoad <= 1'b0;
        end else begin
            irq.videoHead <= hitVideo;
            irq.audioHead <= hitAudio;
            irq.pseudoVsync <= hitPseudo;
            irq.vsyncMask <= hitVmask;
            irq.intervalA <= tick[TK_1US] && hitIntA;
            irq.intervalB <= tick[TK_2US] && hitIntB;
            irq.tape <= tapeMatch || tapeUnder;
            irq.remote <= pinRise[PIN_EXT];
            irq.dutyPeriod <= pinRise[PIN_PLAYBACK_CONTROL_PULSE];
            case (rtpTriggerSel)
                RTP_SEL_VIDEO: realtimeOutputLoad <= hitVideo;
                RTP_SEL_AUDIO: realtimeOutputLoad <= hitAudio;
                RTP_SEL_PSEUDO: realtimeOutputLoad <= hitPseudo;
                RTP_SEL_VMASK: realtimeOutputLoad <= hitVmask;
                RTP_SEL_INTB: realtimeOutputLoad <= tick[TK_2US] && hitIntB;
                default: realtimeOutputLoad <= 1'b0;
            endcase
        end
    end

    // pwm: one shared carrier; duty scaled onto the carrier period
    logic [PWM_CNT_W-1:0] pwmCarrier;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pwmCarrier <= '0;
        end else if (pwmCarrier == PWM_CNT_W'(PWM_CYC - 1)) begin
            pwmCarrier <= '0;
        end else begin
            pwmCarrier <= pwmCarrier + 1'b1;
        end
    end

    for (genvar p = 0; p < NUM_PWM_HI + NUM_PWM_LO; p++) begin : gPwm
        logic [PWM_HI_W+PWM_CNT_W-1:0] scaled;
        logic [PWM_CNT_W-1:0] thresh;
        if (p < NUM_PWM_HI) begin : gWide
            assign scaled = pwmDuty.wide[p] * (PWM_HI_W+PWM_CNT_W)'(PWM_CYC);
            assign thresh = scaled[PWM_HI_W +: PWM_CNT_W];
        end else begin : gNarrow
            assign scaled = {8'h00, pwmDuty.narrow[p-NUM_PWM_HI]} *
                            (PWM_HI_W+PWM_CNT_W)'(PWM_CYC);
            assign thresh = scaled[PWM_LO_W +: PWM_CNT_W];
        end
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                pwmOut[p] <= 1'b0;
            end else begin
                pwmOut[p] <= pwmCarrier < thresh;
            end
        end
    end
endmodule

//--- core/vstu_pkg.sv
// Purpose: shared constants and carrier types for the servo timer unit
// Assumes: one 40 MHz system clock
// Notes: all counters and registers reset to zero
package vstu_pkg;

    // clock and tick periods in picoseconds
    localparam int CLK_PERIOD_PS = 25000;
    localparam int TICK_1US_PS = 1000000;
    localparam int TICK_1P1US_PS = 1100000;
    localparam int TICK_125NS_PS = 125000;
    localparam int TICK_2US_PS = 2000000;
    localparam int PWM_CARRIER_PS = 16000000;

    // derived cycle counts
    localparam int DIV_1US = TICK_1US_PS / CLK_PERIOD_PS;
    localparam int DIV_1P1US = TICK_1P1US_PS / CLK_PERIOD_PS;
    localparam int DIV_125NS = TICK_125NS_PS / CLK_PERIOD_PS;
    localparam int DIV_2US = TICK_2US_PS / CLK_PERIOD_PS;
    localparam int PWM_PERIOD_CYC = PWM_CARRIER_PS / CLK_PERIOD_PS;

    // tick generator indices
    localparam int TK_1US = 0;
    localparam int TK_1P1US = 1;
    localparam int TK_125NS = 2;
    localparam int TK_2US = 3;
    localparam int NUM_TICKS = 4;
    localparam int TICK_CNT_W = 8;

    // widths
    localparam int HEAD_W = 16;
    localparam int EVT_W = 8;
    localparam int FRC_W = 22;
    localparam int TMR_W = 16;
    localparam int TAPE_W = 5;
    localparam int PWM_HI_W = 16;
    localparam int PWM_LO_W = 8;
    localparam int PWM_CNT_W = 10;
    localparam int NUM_PWM_HI = 3;
    localparam int NUM_PWM_LO = 3;
    localparam int NUM_FRC_CAPT = 6;

    // synchronised pin indices
    localparam int PIN_DRUM_PHASE = 0;
    localparam int PIN_DRUM_FREQ = 1;
    localparam int PIN_REF = 2;
    localparam int PIN_CAPSTAN = 3;
    localparam int PIN_TAKEUP = 4;
    localparam int PIN_SUPPLY = 5;
    localparam int PIN_PLAYBACK_CONTROL_PULSE = 6;
    localparam int PIN_EXT = 7;
    localparam int NUM_PINS = 8;

    // realtime output port trigger select codes
    localparam logic [2:0] RTP_SEL_VIDEO = 3'h0;
    localparam logic [2:0] RTP_SEL_AUDIO = 3'h1;
    localparam logic [2:0] RTP_SEL_PSEUDO = 3'h2;
    localparam logic [2:0] RTP_SEL_VMASK = 3'h3;
    localparam logic [2:0] RTP_SEL_INTB = 3'h4;

    typedef struct packed {
        logic [HEAD_W-1:0] videoHeadDelay;
        logic [HEAD_W-1:0] audioHeadDelay;
        logic [HEAD_W-1:0] pseudoVsync;
        logic [3:0][EVT_W-1:0] drumEvent;
        logic [TMR_W-1:0] frameReference;
        logic [TMR_W-1:0] recordControl;
        logic [TMR_W-1:0] vsyncMask;
        logic [1:0][TMR_W-1:0] dutySample;
        logic [EVT_W-1:0] tachDivider;
        logic [TMR_W-1:0] intervalA;
        logic [TMR_W-1:0] intervalB;
        logic [TAPE_W-1:0] tape;
    } vstu_compare_t;

    typedef struct packed {
        logic [NUM_FRC_CAPT-1:0][FRC_W-1:0] freeRun;
        logic [TMR_W-1:0] capstanPhase;
        logic [TMR_W-1:0] pulsePeriod;
        logic [TMR_W-1:0] remoteDuty;
        logic [TMR_W-1:0] remotePeriod;
    } vstu_capture_t;

    typedef struct packed {
        logic videoHead;
        logic audioHead;
        logic pseudoVsync;
        logic vsyncMask;
        logic intervalA;
        logic intervalB;
        logic tape;
        logic remote;
        logic dutyPeriod;
    } vstu_irq_t;

    typedef struct packed {
        logic [NUM_PWM_HI-1:0][PWM_HI_W-1:0] wide;
        logic [NUM_PWM_LO-1:0][PWM_LO_W-1:0] narrow;
    } vstu_pwm_duty_t;

endpackage

//--- core/vstu_edge_sync.sv
// Purpose: two-flop synchroniser with registered edge pulses for tach pins
// Assumes: pins are asynchronous to sys_clk
// Notes: rise and fall are one-cycle pulses, two to three cycles after the pin
`timescale 1ns/1ps
module vstu_edge_sync #(
    parameter int N = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // pins
    input wire logic [N-1:0] pinIn,
    // synchronised view
    output logic [N-1:0] level,
    output logic [N-1:0] rise,
    output logic [N-1:0] fall
);
    logic [N-1:0] meta;
    logic [N-1:0] prev;

    // first stage is read only by the second stage
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            level <= '0;
            prev <= '0;
        end else begin
            meta <= pinIn;
            level <= meta;
            prev <= level;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rise <= '0;
            fall <= '0;
        end else begin
            rise <= level & ~prev;
            fall <= ~level & prev;
        end
    end
endmodule

//--- sim/vstu_timer_unit_asserts.sv
// Purpose: port checks for the servo timer unit
// Assumes: compare inputs stay static once reset is released
// Notes: pin based checks expect pins held for several clocks
`timescale 1ns/1ps
module vstu_timer_unit_asserts
    import vstu_pkg::*;
#(
    parameter int PWM_CYC = PWM_PERIOD_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // watched inputs
    input wire logic playback_control_pulse,
    input wire logic external_capture_pin,
    input wire vstu_compare_t compare,
    input wire logic [2:0] rtpTriggerSel,
    // watched outputs
    input wire vstu_capture_t capture,
    input wire vstu_irq_t irq,
    input wire logic realtimeOutputLoad,
    input wire logic vsyncUnmask,
    input wire logic [TAPE_W-1:0] tapeCount
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    int gapA;
    int gapB;
    logic seenA;
    logic seenB;
    // spacing of interval interrupts; the first pulse only arms the check
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gapA <= 0;
            gapB <= 0;
            seenA <= 1'b0;
            seenB <= 1'b0;
        end else begin
            gapA <= irq.intervalA ? 1 : gapA + 1;
            gapB <= irq.intervalB ? 1 : gapB + 1;
            seenA <= seenA | irq.intervalA;
            seenB <= seenB | irq.intervalB;
        end
    end
    sequence load_late_s;
        ##1 realtimeOutputLoad;
    endsequence
    reset_clear_a: assert property ($fell(rst) |-> capture == '0 && tapeCount == '0)
        else $error("outputs not clear after reset");
    remote_pair_a: assert property (capture.remoteDuty == capture.remotePeriod)
        else $error("remote captures differ");
    remote_cause_a: assert property ($changed(capture.remoteDuty) |->
        $past(external_capture_pin, 3) || $past(external_capture_pin, 4))
        else $error("remote capture without pin edge");
    interval_a_gap_a: assert property (irq.intervalA && seenA |->
        gapA == (int'(compare.intervalA) + 1) * DIV_1US)
        else $error("interval a period wrong");
    interval_b_gap_a: assert property (irq.intervalB && seenB |->
        gapB == (int'(compare.intervalB) + 1) * DIV_2US)
        else $error("interval b period wrong");
    tape_step_a: assert property ($changed(tapeCount) |->
        (tapeCount == $past(tapeCount) + 5'h01 && $past(playback_control_pulse, 3)) ||
        (tapeCount == $past(tapeCount) - 5'h01 && !$past(playback_control_pulse, 3)))
        else $error("tape counter stepped wrongly");
    tape_irq_a: assert property (irq.tape |->
        tapeCount == compare.tape || tapeCount == 5'h1f)
        else $error("tape interrupt without match");
    vsync_unmask_a: assert property (vsyncUnmask |->
        (irq.vsyncMask || $past(irq.vsyncMask)) or ##1 irq.vsyncMask)
        else $error("unmask without mask coincidence");
    // the load was registered with last cycle's select, so that must be interval b too
    port_load_a: assert property (irq.intervalB && rtpTriggerSel == RTP_SEL_INTB &&
        $past(rtpTriggerSel) == RTP_SEL_INTB |->
        (realtimeOutputLoad || $past(realtimeOutputLoad)) or load_late_s)
        else $error("port load missing on interval b");
endmodule
bind vstu_timer_unit vstu_timer_unit_asserts #(.PWM_CYC(PWM_CYC)) chk_u (
    .sys_clk(sys_clk), .rst(rst), .playback_control_pulse(playback_control_pulse),
    .external_capture_pin(external_capture_pin), .compare(compare),
    .rtpTriggerSel(rtpTriggerSel), .capture(capture), .irq(irq),
    .realtimeOutputLoad(realtimeOutputLoad), .vsyncUnmask(vsyncUnmask),
    .tapeCount(tapeCount)
);

//--- sim/vstu_tach_model.sv
// Purpose: motor tach, sync and control pulse sources
// Assumes: pin index order of the package
// Notes: pins move just after the falling edge, away from sampling
`timescale 1ns/1ps
module vstu_tach_model
    import vstu_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // pins toward the unit
    output logic [NUM_PINS-1:0] pins
);
    initial begin
        pins = '0;
    end
    task automatic pulse(input logic [NUM_PINS-1:0] mask, input int width);
        @(negedge sys_clk);
        pins = pins | mask;
        repeat (width) @(negedge sys_clk);
        pins = pins & ~mask;
    endtask
    task automatic level(input int idx, input logic v);
        @(negedge sys_clk);
        pins[idx] = v;
    endtask
endmodule

//--- sim/test_vstu_timer_unit.sv
// Purpose: self-checking bench for the servo timer unit
// Assumes: head, vsync mask, interval and tape compares are random but small so coincidences come quickly
// Notes: capture checks use deltas, so sync latency cancels out
`timescale 1ns/1ps
module test_vstu_timer_unit
    import vstu_pkg::*;
;
    localparam int SPAN = 12;
    localparam int PW = $bits(vstu_pwm_duty_t);
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [NUM_PINS-1:0] pins;
    vstu_compare_t compare = '0;
    vstu_pwm_duty_t pwmDuty = '0;
    logic dutyTickSlow = 1'b0;
    logic [2:0] rtpTriggerSel = RTP_SEL_INTB;
    vstu_capture_t capture;
    vstu_capture_t snap;
    vstu_irq_t irq;
    logic realtimeOutputLoad;
    logic [TAPE_W-1:0] tapeCount;
    logic [NUM_PWM_HI+NUM_PWM_LO-1:0] pwmOut;
    int loadCount = 0;
    int tapeIrqCount = 0;
    int mark;
    int pwmExp;
    int pwmHigh [6];
    int snapHigh [6];
    int bad_count = 0;
    int comparisons = 0;
    int seed;
    int tapeModel = 0;
    int gapA = 0;
    int gapB = 0;
    int periodA = 0;
    int periodB = 0;
    vstu_tach_model model_u (.sys_clk(sys_clk), .pins(pins));
    vstu_timer_unit #(.PWM_CYC(16)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .drumPhaseTach(pins[PIN_DRUM_PHASE]),
        .drumFreqTach(pins[PIN_DRUM_FREQ]), .referenceSync(pins[PIN_REF]),
        .capstanTach(pins[PIN_CAPSTAN]), .takeupReelTach(pins[PIN_TAKEUP]),
        .supplyReelTach(pins[PIN_SUPPLY]), .playback_control_pulse(pins[PIN_PLAYBACK_CONTROL_PULSE]),
        .external_capture_pin(pins[PIN_EXT]), .compare(compare), .pwmDuty(pwmDuty),
        .dutyTickSlow(dutyTickSlow), .rtpTriggerSel(rtpTriggerSel), .capture(capture),
        .irq(irq), .realtimeOutputLoad(realtimeOutputLoad), .vsyncUnmask(),
        .videoHeadSwitch(), .audioHeadSwitch(), .pseudoVsyncPulse(),
        .record_control_output(), .dutySample(), .tachDividerOut(),
        .tapeCount(tapeCount), .pwmOut(pwmOut)
    );
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        gapA <= irq.intervalA ? 1 : gapA + 1;
        gapB <= irq.intervalB ? 1 : gapB + 1;
        if (irq.intervalA) periodA <= gapA;
        if (irq.intervalB) periodB <= gapB;
        if (realtimeOutputLoad) loadCount <= loadCount + 1;
        if (irq.tape) tapeIrqCount <= tapeIrqCount + 1;
        foreach (pwmHigh[p]) pwmHigh[p] <= pwmHigh[p] + int'(pwmOut[p]);
    end
    task automatic check_val(input string what, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, e, g);
        end
    endtask
    task automatic check_flag(input string what, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // two pulses exactly SPAN ticks apart; snap holds the first captures
    task automatic span_test(input logic [NUM_PINS-1:0] mask, input int div);
        model_u.pulse(mask, 8);
        repeat (10) @(negedge sys_clk);
        snap = capture;
        repeat (SPAN * div - 19) @(negedge sys_clk);
        model_u.pulse(mask, 8);
        repeat (10) @(negedge sys_clk);
    endtask
    initial begin
        repeat (40000) @(posedge sys_clk);
        bad_count++;
        complete_run();
    end
    initial begin
        seed = 87;
        compare.videoHeadDelay = 16'($random(seed) & 15) + 16'h0002;
        compare.audioHeadDelay = 16'($random(seed) & 15) + 16'h0002;
        compare.pseudoVsync = 16'($random(seed) & 15) + 16'h0002;
        compare.vsyncMask = 16'($random(seed) & 15) + 16'h0002;
        compare.intervalA = 16'($random(seed) & 15);
        compare.intervalB = 16'($random(seed) & 15);
        compare.tape = 5'($random(seed) & 1);
        compare.drumEvent = '1;
        compare.tachDivider = 8'hff;
        pwmDuty = PW'({$random(seed), $random(seed), $random(seed)});
        dutyTickSlow = 1'($random(seed));
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        check_flag("capture clear", 1'b1, capture == '0);
        check_flag("tape clear", 1'b1, tapeCount == '0);
        $display("done: reset");
        span_test(NUM_PINS'(8'h3f), DIV_125NS);
        for (int i = 0; i < NUM_FRC_CAPT; i++) begin
            check_val("free run", SPAN, capture.freeRun[i] - snap.freeRun[i]);
        end
        $display("done: free running captures");
        span_test(NUM_PINS'(1) << PIN_EXT, DIV_2US);
        check_val("remote duty span", SPAN, capture.remoteDuty - snap.remoteDuty);
        check_val("remote period span", SPAN, capture.remotePeriod - snap.remotePeriod);
        $display("done: remote captures");
        repeat (2800) @(negedge sys_clk);
        check_val("interval a period", (compare.intervalA + 1) * DIV_1US, periodA);
        check_val("interval b period", (compare.intervalB + 1) * DIV_2US, periodB);
        $display("done: interval timers");
        for (int i = 0; i < 8; i++) begin
            mark = tapeIrqCount;
            model_u.level(PIN_PLAYBACK_CONTROL_PULSE, ~pins[PIN_PLAYBACK_CONTROL_PULSE]);
            tapeModel = pins[PIN_PLAYBACK_CONTROL_PULSE] ? tapeModel + 1 : tapeModel - 1;
            repeat (10) @(negedge sys_clk);
            check_val("tape count", tapeModel & 31, tapeCount);
            check_val("tape irq", (tapeModel & 31) == compare.tape, tapeIrqCount - mark);
        end
        $display("done: tape counter");
        // carrier is 16 clocks here, so 160 clocks hold ten whole periods
        snapHigh = pwmHigh;
        repeat (160) @(negedge sys_clk);
        for (int p = 0; p < 6; p++) begin
            pwmExp = p < 3 ? (pwmDuty.wide[p % 3] * 16) >> 16 : (pwmDuty.narrow[p % 3] * 16) >> 8;
            check_val("pwm high", 10 * pwmExp, pwmHigh[p] - snapHigh[p]);
        end
        $display("done: pwm");
        // codes 0..3, then an unused code that must stay quiet, then interval b
        for (int s = 0; s < 6; s++) begin
            rtpTriggerSel = (s == 4) ? 3'h7 : (s == 5) ? RTP_SEL_INTB : 3'(s);
            mark = loadCount;
            model_u.pulse(NUM_PINS'(1) << ((s == 3) ? PIN_REF : PIN_DRUM_PHASE), 8);
            for (int w = 0; w < 2000 && loadCount == mark; w++) @(negedge sys_clk);
            check_val("port load", s != 4, loadCount - mark);
        end
        $display("done: port triggers");
        complete_run();
    end
endmodule
